// ---- cisd_map.vh ----
// register map, field positions, reset values and decode codes of the compact decoder
`ifndef CISD_MAP_VH
`define CISD_MAP_VH
// register byte offsets
`define CISD_OFS_CTRL     8'h00
`define CISD_OFS_STAT     8'h04
`define CISD_OFS_XCNT     8'h08
// control fields and reset values
`define CISD_CTRL_EN_BIT  0
`define CISD_CTRL_CLR_BIT 1
`define CISD_CTRL_EN_RST  1'b1
// status fields
`define CISD_STAT_CMP_BIT 0
`define CISD_STAT_SAV_BIT 1
`define CISD_STAT_LBP_BIT 2
`define CISD_STAT_FLG_LSB 4
`define CISD_XCNT_W       16
// fetch geometry
`define CISD_STEP_WIDE    3'h4
`define CISD_STEP_CMP     3'h2
`define CISD_HALF_SEL_BIT 1
`define CISD_REG_SP       4'hd
`define CISD_REG_LR       4'he
`define CISD_REG_PC       4'hf
// access sizes
`define CISD_SZ_BYTE      2'h0
`define CISD_SZ_HALF      2'h1
`define CISD_SZ_WORD      2'h2
// shift kinds (same codes as the two-operand alu op field)
`define CISD_SH_LSL       4'h2
`define CISD_SH_LSR       4'h3
`define CISD_SH_ASR       4'h4
`define CISD_SH_ROR       4'h7
// instruction classes
`define CISD_C_NONE       5'h00
`define CISD_C_SHIFT      5'h01
`define CISD_C_ADDSUB     5'h02
`define CISD_C_IMM8       5'h03
`define CISD_C_ALU        5'h04
`define CISD_C_HIREG      5'h05
`define CISD_C_PCLOAD     5'h06
`define CISD_C_LDST_REG   5'h07
`define CISD_C_LDST_SX    5'h08
`define CISD_C_LDST_IMM   5'h09
`define CISD_C_LDST_HALF  5'h0a
`define CISD_C_SP_LDST    5'h0b
`define CISD_C_LOAD_ADDR  5'h0c
`define CISD_C_SP_ADJ     5'h0d
`define CISD_C_PUSHPOP    5'h0e
`define CISD_C_MULTI      5'h0f
`define CISD_C_CBRANCH    5'h10
`define CISD_C_TRAP       5'h11
`define CISD_C_UBRANCH    5'h12
`define CISD_C_LONG_HI    5'h13
`define CISD_C_LONG_LO    5'h14
// branch condition codes
`define CISD_CC_EQ        4'h0
`define CISD_CC_NE        4'h1
`define CISD_CC_CS        4'h2
`define CISD_CC_CC        4'h3
`define CISD_CC_MI        4'h4
`define CISD_CC_PL        4'h5
`define CISD_CC_VS        4'h6
`define CISD_CC_VC        4'h7
`define CISD_CC_HI        4'h8
`define CISD_CC_LS        4'h9
`define CISD_CC_GE        4'ha
`define CISD_CC_LT        4'hb
`define CISD_CC_GT        4'hc
`define CISD_CC_LE        4'hd
`define CISD_CC_AL        4'he
`endif

// ---- cisd_cond.v ----
// branch condition evaluator on the n, z, c and v flags
`default_nettype none
`include "cisd_map.vh"
module cisd_cond (
   input  wire [3:0] cond,
   input  wire       flag_n,
   input  wire       flag_z,
   input  wire       flag_c,
   input  wire       flag_v,
   output reg        pass
);
   always @* begin
      case (cond)
         `CISD_CC_EQ: pass = flag_z;
         `CISD_CC_NE: pass = ~flag_z;
         `CISD_CC_CS: pass = flag_c;
         `CISD_CC_CC: pass = ~flag_c;
         `CISD_CC_MI: pass = flag_n;
         `CISD_CC_PL: pass = ~flag_n;
         `CISD_CC_VS: pass = flag_v;
         `CISD_CC_VC: pass = ~flag_v;
         `CISD_CC_HI: pass = flag_c & ~flag_z;
         `CISD_CC_LS: pass = ~flag_c | flag_z;
         `CISD_CC_GE: pass = (flag_n == flag_v);
         `CISD_CC_LT: pass = (flag_n != flag_v);
         `CISD_CC_GT: pass = ~flag_z & (flag_n == flag_v);
         `CISD_CC_LE: pass = flag_z | (flag_n != flag_v);
         `CISD_CC_AL: pass = 1'b1;
         default: pass = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ---- cisd_top.v ----
// compact instruction decoder and execution state control with a wishbone register slave
`default_nettype none
`include "cisd_map.vh"
module cisd_top (
   input  wire        CLOCK,
   input  wire        RST,
   input  wire [31:0] FETCH_WORD,
   input  wire        FETCH_VALID,
   input  wire [31:0] PC,
   input  wire        FLAG_N,
   input  wire        FLAG_Z,
   input  wire        FLAG_C,
   input  wire        FLAG_V,
   input  wire        XCHG_COMMIT,
   input  wire        XCHG_TARGET_BIT0,
   input  wire        EXC_TAKE,
   input  wire        EXC_RETURN,
   input  wire        RET_STATE,
   input  wire        WB_CYC_I,
   input  wire        WB_STB_I,
   input  wire        WB_WE_I,
   input  wire [7:0]  WB_ADR_I,
   input  wire [3:0]  WB_SEL_I,
   input  wire [31:0] WB_DAT_I,
   output reg  [31:0] WB_DAT_O,
   output reg         WB_ACK_O,
   output reg         STATE_COMPACT,
   output reg         SAVED_STATE,
   output wire [2:0]  PC_STEP,
   output reg         WIDE_VALID,
   output reg         DEC_VALID,
   output reg  [4:0]  DEC_CLASS,
   output reg  [3:0]  DEC_SUBOP,
   output reg  [3:0]  DEC_RD,
   output reg  [3:0]  DEC_RS,
   output reg  [3:0]  DEC_RO,
   output reg  [31:0] DEC_IMM,
   output reg         DEC_IMM_SEL,
   output reg  [1:0]  DEC_SIZE,
   output reg         DEC_SIGNED,
   output reg         DEC_LOAD,
   output reg         DEC_WRITEBACK,
   output reg  [7:0]  DEC_REGLIST,
   output reg         DEC_LR_PC,
   output reg         DEC_POP_RETURN,
   output reg         DEC_BR_TAKEN,
   output reg         DEC_LINK,
   output reg         DEC_XCHG,
   output reg         DEC_XCHG_HIGH
);
   localparam [1:0] LB_IDLE = 2'b01;
   localparam [1:0] LB_HIGH = 2'b10;

   reg                     ctrl_en_ff;
   reg  [`CISD_XCNT_W-1:0] xcnt_ff;
   reg  [1:0]              lb_ff;
   reg  [31:0]             lb_hi_ff;
   reg  [1:0]              nxt_lb;
   reg  [31:0]             nxt_lb_hi;
   reg  [4:0]              nxt_class;
   reg  [3:0]              nxt_subop;
   reg  [3:0]              nxt_rd;
   reg  [3:0]              nxt_rs;
   reg  [3:0]              nxt_ro;
   reg  [31:0]             nxt_imm;
   reg                     nxt_imm_sel;
   reg  [1:0]              nxt_size;
   reg                     nxt_signed;
   reg                     nxt_load;
   reg                     nxt_wb;
   reg  [7:0]              nxt_list;
   reg                     nxt_lr_pc;
   reg                     nxt_ret;
   reg                     nxt_taken;
   reg                     nxt_link;
   reg                     nxt_xchg;
   reg                     nxt_xhigh;
   reg                     nxt_state;
   reg  [31:0]             nxt_rdata;
   wire [15:0]             hw;
   wire                    cond_pass;
   wire                    dec_go;
   wire                    wb_req;
   wire                    wb_wr;

   function [31:0] sext11;
      input [10:0] v;
      begin
         sext11 = {{21{v[10]}}, v};
      end
   endfunction

   // number of registers moved, times four, for the final base address
   function [31:0] list_bytes;
      input [8:0] l;
      integer     i;
      reg   [3:0] n;
      begin
         n = 4'h0;
         for (i = 0; i < 9; i = i + 1) begin
            n = n + {3'h0, l[i]};
         end
         list_bytes = {26'h0, n, 2'b00};
      end
   endfunction

   assign hw = PC[`CISD_HALF_SEL_BIT] ? FETCH_WORD[31:16] : FETCH_WORD[15:0];
   assign PC_STEP = STATE_COMPACT ? `CISD_STEP_CMP : `CISD_STEP_WIDE;
   assign dec_go = FETCH_VALID & STATE_COMPACT & ctrl_en_ff;
   assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign wb_wr = wb_req & WB_WE_I;

   cisd_cond u_cond (
      .cond   (hw[11:8]),
      .flag_n (FLAG_N),
      .flag_z (FLAG_Z),
      .flag_c (FLAG_C),
      .flag_v (FLAG_V),
      .pass   (cond_pass)
   );

   // combinational decode of the selected halfword
   always @* begin
      nxt_lb = lb_ff;
      nxt_lb_hi = lb_hi_ff;
      nxt_class = `CISD_C_NONE;
      nxt_subop = 4'h0;
      nxt_rd = {1'b0, hw[2:0]};
      nxt_rs = {1'b0, hw[5:3]};
      nxt_ro = {1'b0, hw[8:6]};
      nxt_imm = 32'h0;
      nxt_imm_sel = 1'b0;
      nxt_size = `CISD_SZ_WORD;
      nxt_signed = 1'b0;
      nxt_load = hw[11];
      nxt_wb = 1'b0;
      nxt_list = 8'h0;
      nxt_lr_pc = 1'b0;
      nxt_ret = 1'b0;
      nxt_taken = 1'b0;
      nxt_link = 1'b0;
      nxt_xchg = 1'b0;
      nxt_xhigh = 1'b0;
      casez (hw[15:11])
         5'b000??: begin
            if (hw[12:11] == 2'b11) begin
               nxt_class = `CISD_C_ADDSUB;
               nxt_subop = {3'h0, hw[9]};
               nxt_imm = {29'h0, hw[8:6]};
               nxt_imm_sel = hw[10];
            end else begin
               nxt_class = `CISD_C_SHIFT;
               nxt_subop = (hw[12:11] == 2'b00) ? `CISD_SH_LSL :
                           (hw[12:11] == 2'b01) ? `CISD_SH_LSR : `CISD_SH_ASR;
               nxt_imm = {27'h0, hw[10:6]};
               nxt_imm_sel = 1'b1;
            end
            nxt_load = 1'b0;
         end
         5'b001??: begin
            nxt_class = `CISD_C_IMM8;
            nxt_subop = {2'h0, hw[12:11]};
            nxt_rd = {1'b0, hw[10:8]};
            nxt_imm = {24'h0, hw[7:0]};
            nxt_imm_sel = 1'b1;
            nxt_load = 1'b0;
         end
         5'b01000: begin
            nxt_load = 1'b0;
            if (!hw[10]) begin
               // shifts and rotate in this group take their amount from rs only
               nxt_class = `CISD_C_ALU;
               nxt_subop = hw[9:6];
            end else begin
               nxt_class = `CISD_C_HIREG;
               nxt_subop = {2'h0, hw[9:8]};
               nxt_rd = {hw[7], hw[2:0]};
               nxt_rs = {hw[6], hw[5:3]};
               if (hw[9:8] == 2'b11) begin
                  nxt_xchg = 1'b1;
                  nxt_xhigh = hw[6];
               end
            end
         end
         5'b01001: begin
            nxt_class = `CISD_C_PCLOAD;
            nxt_rd = {1'b0, hw[10:8]};
            nxt_rs = `CISD_REG_PC;
            nxt_imm = {22'h0, hw[7:0], 2'b00};
            nxt_imm_sel = 1'b1;
            nxt_load = 1'b1;
         end
         5'b0101?: begin
            if (!hw[9]) begin
               nxt_class = `CISD_C_LDST_REG;
               nxt_size = hw[10] ? `CISD_SZ_BYTE : `CISD_SZ_WORD;
            end else begin
               nxt_class = `CISD_C_LDST_SX;
               nxt_load = hw[10] | hw[11];
               nxt_signed = hw[10];
               nxt_size = (hw[10] & ~hw[11]) ? `CISD_SZ_BYTE : `CISD_SZ_HALF;
            end
         end
         5'b011??: begin
            nxt_class = `CISD_C_LDST_IMM;
            nxt_imm_sel = 1'b1;
            nxt_size = hw[12] ? `CISD_SZ_BYTE : `CISD_SZ_WORD;
            nxt_imm = hw[12] ? {27'h0, hw[10:6]} :
                               {25'h0, hw[10:6], 2'b00};
         end
         5'b1000?: begin
            nxt_class = `CISD_C_LDST_HALF;
            nxt_imm_sel = 1'b1;
            nxt_size = `CISD_SZ_HALF;
            nxt_imm = {26'h0, hw[10:6], 1'b0};
         end
         5'b1001?: begin
            nxt_class = `CISD_C_SP_LDST;
            nxt_rd = {1'b0, hw[10:8]};
            nxt_rs = `CISD_REG_SP;
            nxt_imm = {22'h0, hw[7:0], 2'b00};
            nxt_imm_sel = 1'b1;
         end
         5'b1010?: begin
            nxt_class = `CISD_C_LOAD_ADDR;
            nxt_rd = {1'b0, hw[10:8]};
            nxt_rs = hw[11] ? `CISD_REG_SP : `CISD_REG_PC;
            nxt_imm = {22'h0, hw[7:0], 2'b00};
            nxt_imm_sel = 1'b1;
            nxt_load = 1'b0;
         end
         5'b1011?: begin
            nxt_rs = `CISD_REG_SP;
            if (hw[10:9] == 2'b10) begin
               nxt_class = `CISD_C_PUSHPOP;
               nxt_list = hw[7:0];
               nxt_lr_pc = hw[8];
               nxt_ret = hw[11] & hw[8];
               nxt_taken = hw[11] & hw[8];
               nxt_wb = 1'b1;
               nxt_imm = list_bytes(hw[8:0]);
            end else if (hw[11:8] == 4'h0) begin
               nxt_class = `CISD_C_SP_ADJ;
               nxt_subop = {3'h0, hw[7]};
               nxt_imm = {23'h0, hw[6:0], 2'b00};
               nxt_imm_sel = 1'b1;
               nxt_load = 1'b0;
            end else begin
               nxt_load = 1'b0;
            end
         end
         5'b1100?: begin
            nxt_class = `CISD_C_MULTI;
            nxt_rs = {1'b0, hw[10:8]};
            nxt_list = hw[7:0];
            nxt_wb = 1'b1;
            nxt_imm = list_bytes({1'b0, hw[7:0]});
         end
         5'b1101?: begin
            nxt_load = 1'b0;
            if (hw[11:8] == 4'hf) begin
               nxt_class = `CISD_C_TRAP;
               nxt_imm = {24'h0, hw[7:0]};
            end else if (hw[11:8] != `CISD_CC_AL) begin
               nxt_class = `CISD_C_CBRANCH;
               nxt_subop = hw[11:8];
               nxt_imm = {{23{hw[7]}}, hw[7:0], 1'b0};
               nxt_taken = cond_pass;
            end
         end
         5'b11100: begin
            nxt_class = `CISD_C_UBRANCH;
            nxt_imm = sext11(hw[10:0]) << 1;
            nxt_taken = 1'b1;
            nxt_load = 1'b0;
         end
         5'b11110: begin
            nxt_class = `CISD_C_LONG_HI;
            nxt_lb = LB_HIGH;
            nxt_lb_hi = sext11(hw[10:0]) << 12;
            nxt_imm = sext11(hw[10:0]) << 12;
            nxt_load = 1'b0;
         end
         5'b11111: begin
            nxt_class = `CISD_C_LONG_LO;
            nxt_lb = LB_IDLE;
            nxt_rd = `CISD_REG_LR;
            nxt_imm = lb_hi_ff + {20'h0, hw[10:0], 1'b0};
            nxt_link = 1'b1;
            nxt_taken = 1'b1;
            nxt_load = 1'b0;
         end
         default: begin
            nxt_load = 1'b0;
         end
      endcase
   end

   // execution state: exception entry beats return, return beats exchange
   always @* begin
      nxt_state = STATE_COMPACT;
      if (EXC_TAKE) begin
         nxt_state = 1'b0;
      end else if (EXC_RETURN) begin
         nxt_state = RET_STATE;
      end else if (XCHG_COMMIT) begin
         nxt_state = XCHG_TARGET_BIT0;
      end
   end

   always @* begin
      case (WB_ADR_I)
         `CISD_OFS_CTRL: nxt_rdata = {31'h0, ctrl_en_ff};
         `CISD_OFS_STAT: nxt_rdata = {24'h0, FLAG_N, FLAG_Z, FLAG_C, FLAG_V,
                                      1'b0, lb_ff[1], SAVED_STATE, STATE_COMPACT};
         `CISD_OFS_XCNT: nxt_rdata = {{(32-`CISD_XCNT_W){1'b0}}, xcnt_ff};
         default: nxt_rdata = 32'h0;
      endcase
   end

   always @(posedge CLOCK) begin
      if (RST) begin
         STATE_COMPACT <= 1'b0;
         SAVED_STATE <= 1'b0;
         ctrl_en_ff <= `CISD_CTRL_EN_RST;
         xcnt_ff <= {`CISD_XCNT_W{1'b0}};
         lb_ff <= LB_IDLE;
         lb_hi_ff <= 32'h0;
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0;
         WIDE_VALID <= 1'b0;
         DEC_VALID <= 1'b0;
         DEC_CLASS <= `CISD_C_NONE;
         DEC_SUBOP <= 4'h0;
         DEC_RD <= 4'h0;
         DEC_RS <= 4'h0;
         DEC_RO <= 4'h0;
         DEC_IMM <= 32'h0;
         DEC_IMM_SEL <= 1'b0;
         DEC_SIZE <= `CISD_SZ_WORD;
         DEC_SIGNED <= 1'b0;
         DEC_LOAD <= 1'b0;
         DEC_WRITEBACK <= 1'b0;
         DEC_REGLIST <= 8'h0;
         DEC_LR_PC <= 1'b0;
         DEC_POP_RETURN <= 1'b0;
         DEC_BR_TAKEN <= 1'b0;
         DEC_LINK <= 1'b0;
         DEC_XCHG <= 1'b0;
         DEC_XCHG_HIGH <= 1'b0;
      end else begin
         // only the state bits move (SAVED_STATE on exception entry); mode and register file are never touched here
         STATE_COMPACT <= nxt_state;
         if (EXC_TAKE) begin
            SAVED_STATE <= STATE_COMPACT;
         end
         WB_ACK_O <= wb_req;
         if (wb_req) begin
            WB_DAT_O <= WB_WE_I ? 32'h0 : nxt_rdata;
         end
         if (wb_wr && WB_ADR_I == `CISD_OFS_CTRL && WB_SEL_I[0]) begin
            ctrl_en_ff <= WB_DAT_I[`CISD_CTRL_EN_BIT];
         end
         // a state change in the same cycle as a clear is still counted
         if (wb_wr && WB_ADR_I == `CISD_OFS_CTRL && WB_SEL_I[0] &&
             WB_DAT_I[`CISD_CTRL_CLR_BIT]) begin
            xcnt_ff <= {{(`CISD_XCNT_W-1){1'b0}}, nxt_state != STATE_COMPACT};
         end else if (nxt_state != STATE_COMPACT) begin
            xcnt_ff <= xcnt_ff + {{(`CISD_XCNT_W-1){1'b0}}, 1'b1};
         end
         if (EXC_TAKE) begin
            lb_ff <= LB_IDLE;
         end else if (dec_go) begin
            lb_ff <= nxt_lb;
            lb_hi_ff <= nxt_lb_hi;
         end
         WIDE_VALID <= FETCH_VALID & ~STATE_COMPACT;
         DEC_VALID <= dec_go;
         if (dec_go) begin
            DEC_CLASS <= nxt_class;
            DEC_SUBOP <= nxt_subop;
            DEC_RD <= nxt_rd;
            DEC_RS <= nxt_rs;
            DEC_RO <= nxt_ro;
            DEC_IMM <= nxt_imm;
            DEC_IMM_SEL <= nxt_imm_sel;
            DEC_SIZE <= nxt_size;
            DEC_SIGNED <= nxt_signed;
            DEC_LOAD <= nxt_load;
            DEC_WRITEBACK <= nxt_wb;
            DEC_REGLIST <= nxt_list;
            DEC_LR_PC <= nxt_lr_pc;
            DEC_POP_RETURN <= nxt_ret;
            DEC_BR_TAKEN <= nxt_taken;
            DEC_LINK <= nxt_link;
            DEC_XCHG <= nxt_xchg;
            DEC_XCHG_HIGH <= nxt_xhigh;
         end
      end
   end
endmodule
`default_nettype wire

// ---- cisd_top_monitor.sv ----
// checker on the ports of the compact decoder
`default_nettype none
module cisd_top_monitor (
   input wire logic       CLOCK,
   input wire logic       RST,
   input wire logic       STATE_COMPACT,
   input wire logic       SAVED_STATE,
   input wire logic [2:0] PC_STEP,
   input wire logic       EXC_TAKE,
   input wire logic       EXC_RETURN,
   input wire logic       RET_STATE,
   input wire logic       XCHG_COMMIT,
   input wire logic       XCHG_TARGET_BIT0,
   input wire logic       FETCH_VALID,
   input wire logic       WIDE_VALID,
   input wire logic       DEC_VALID,
   input wire logic [4:0] DEC_CLASS,
   input wire logic [3:0] DEC_SUBOP,
   input wire logic       DEC_BR_TAKEN,
   input wire logic       FLAG_C,
   input wire logic       FLAG_Z,
   input wire logic       WB_CYC_I,
   input wire logic       WB_STB_I,
   input wire logic       WB_ACK_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   property p_step; PC_STEP == (STATE_COMPACT ? 3'h2 : 3'h4); endproperty
   a_step: assert property (p_step) else $error("pc step off");
   property p_exc; EXC_TAKE |=> !STATE_COMPACT && SAVED_STATE == $past(STATE_COMPACT); endproperty
   a_exc: assert property (p_exc) else $error("exception entry");
   property p_ret; !EXC_TAKE && EXC_RETURN |=> STATE_COMPACT == $past(RET_STATE); endproperty
   a_ret: assert property (p_ret) else $error("exception return");
   property p_xchg;
      !EXC_TAKE && !EXC_RETURN && XCHG_COMMIT |=> STATE_COMPACT == $past(XCHG_TARGET_BIT0);
   endproperty
   a_xchg: assert property (p_xchg) else $error("exchange state");
   property p_hold;
      !(EXC_TAKE || EXC_RETURN || XCHG_COMMIT) |=> $stable(STATE_COMPACT);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved");
   property p_wide; FETCH_VALID && !STATE_COMPACT |=> WIDE_VALID && !DEC_VALID; endproperty
   a_wide: assert property (p_wide) else $error("wide fetch");
   property p_dec; DEC_VALID |-> $past(FETCH_VALID && STATE_COMPACT); endproperty
   a_dec: assert property (p_dec) else $error("stray decode");
   property p_hi;
      DEC_VALID && DEC_CLASS == 5'h10 && DEC_SUBOP == 4'h8 |->
         DEC_BR_TAKEN == $past(FLAG_C && !FLAG_Z);
   endproperty
   a_hi: assert property (p_hi) else $error("higher branch");
   property p_ls;
      DEC_VALID && DEC_CLASS == 5'h10 && DEC_SUBOP == 4'h9 |->
         DEC_BR_TAKEN == $past(!FLAG_C || FLAG_Z);
   endproperty
   a_ls: assert property (p_ls) else $error("lower or same branch");
   property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
   a_ack: assert property (p_ack) else $error("bus answer");
endmodule
`default_nettype wire

// ---- cisd_mem_model.sv ----
// memory side model presenting fetched words with a valid strobe
`default_nettype none
module cisd_mem_model (
   input  wire logic        clk,
   input  wire logic        req,
   input  wire logic [15:0] hw,
   input  wire logic        pc1,
   output var  logic [31:0] word,
   output var  logic        valid,
   output var  logic [31:0] pc
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      word = 32'h0;
      valid = 1'b0;
      pc = 32'h0;
   end
   // idle word flips each cycle so a stale lane never looks valid
   always @(posedge clk) begin
      valid <= req;
      pc <= {30'h0, pc1, 1'b0};
      word <= req ? (pc1 ? {hw, ~hw} : {~hw, hw}) : ~word;
   end
endmodule
`default_nettype wire

// ---- tb_cisd_top.sv ----
// self-checking bench of the compact decoder
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %0t got %h exp %h", $time, (g), (e)); end end
module tb_cisd_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1, req = 1'b0, pc1 = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [15:0] hw = 16'h0;
   logic [3:0]  nzcv = 4'h0;
   logic [4:0]  ev = 5'h0;
   logic [7:0]  adr = 8'h0;
   logic [31:0] wdat = 32'h0, rd, fw, pcw, wdo, imm;
   logic        fv, ack, sc, ss, wv, dv, tk, lnk, xg, xh, pr;
   logic [2:0]  step;
   logic [4:0]  cls;
   logic [3:0]  sub;
   logic        isl, sgn, ld, wbk, lrp;
   logic [1:0]  sz;
   logic [3:0]  drd, drs, dro;
   logic [7:0]  rl;
   int          num_errors = 0, checks_done = 0, cycles = 0;
   // {imm_sel, size, signed, load, writeback, lr_pc}, halfword, class, subop,
   // immediate (all ones: unchecked), {taken, link, xchg, high, return}
   logic [68:0] rows [32] = '{
      {7'h60, 16'h07ca, 5'h01, 4'h2, 32'h1f, 5'h00},
      {7'h60, 16'h0840, 5'h01, 4'h3, 32'h01, 5'h00},
      {7'h60, 16'h1140, 5'h01, 4'h4, 32'h05, 5'h00},
      {7'h20, 16'h41c0, 5'h04, 4'h7, 32'hffffffff, 5'h00},
      {7'h64, 16'h6fc0, 5'h09, 4'h0, 32'h7c, 5'h00},
      {7'h54, 16'h8fc0, 5'h0a, 4'h0, 32'h3e, 5'h00},
      {7'h44, 16'h7fc0, 5'h09, 4'h0, 32'h1f, 5'h00},
      {7'h1c, 16'h5e4a, 5'h08, 4'h0, 32'hffffffff, 5'h00},
      {7'h64, 16'h48ff, 5'h06, 4'h0, 32'h3fc, 5'h00},
      {7'h64, 16'h98ff, 5'h0b, 4'h0, 32'h3fc, 5'h00},
      {7'h60, 16'h67c0, 5'h09, 4'h0, 32'h7c, 5'h00},
      {7'h60, 16'h90ff, 5'h0b, 4'h0, 32'h3fc, 5'h00},
      {7'h26, 16'hc8ff, 5'h0f, 4'h0, 32'h20, 5'h00},
      {7'h23, 16'hb501, 5'h0e, 4'h0, 32'h08, 5'h00},
      {7'h27, 16'hbd01, 5'h0e, 4'h0, 32'h08, 5'h11},
      {7'h20, 16'he7ff, 5'h12, 4'h0, 32'hfffffffe, 5'h10},
      {7'h20, 16'hf001, 5'h13, 4'h0, 32'hffffffff, 5'h00},
      {7'h20, 16'hf802, 5'h14, 4'h0, 32'h1004, 5'h18},
      {7'h20, 16'h4708, 5'h05, 4'h0, 32'hffffffff, 5'h04},
      {7'h20, 16'h4748, 5'h05, 4'h0, 32'hffffffff, 5'h06},
      {7'h14, 16'h5a4a, 5'h08, 4'h0, 32'hffffffff, 5'h00},
      {7'h0c, 16'h564a, 5'h08, 4'h0, 32'hffffffff, 5'h00},
      {7'h04, 16'h5c4a, 5'h07, 4'h0, 32'hffffffff, 5'h00},
      {7'h24, 16'h584a, 5'h07, 4'h0, 32'hffffffff, 5'h00},
      {7'h10, 16'h524a, 5'h08, 4'h0, 32'hffffffff, 5'h00},
      {7'h00, 16'h544a, 5'h07, 4'h0, 32'hffffffff, 5'h00},
      {7'h60, 16'h1c4a, 5'h02, 4'h0, 32'h01, 5'h00},
      {7'h60, 16'h2101, 5'h03, 4'h0, 32'h01, 5'h00},
      {7'h60, 16'ha8ff, 5'h0c, 4'h0, 32'h3fc, 5'h00},
      {7'h60, 16'hb081, 5'h0d, 4'h0, 32'h04, 5'h00},
      {7'h20, 16'hdf05, 5'h11, 4'h0, 32'h05, 5'h00},
      {7'h20, 16'hde00, 5'h00, 4'h0, 32'hffffffff, 5'h00}};
   cisd_mem_model mem (.clk(clk), .req(req), .hw(hw), .pc1(pc1), .word(fw), .valid(fv), .pc(pcw));
   cisd_top dut (
      .CLOCK(clk), .RST(rst), .FETCH_WORD(fw), .FETCH_VALID(fv), .PC(pcw),
      .FLAG_N(nzcv[3]), .FLAG_Z(nzcv[2]), .FLAG_C(nzcv[1]), .FLAG_V(nzcv[0]),
      .XCHG_COMMIT(ev[1]), .XCHG_TARGET_BIT0(ev[0]), .EXC_TAKE(ev[4]),
      .EXC_RETURN(ev[3]), .RET_STATE(ev[2]), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(wdo), .WB_ACK_O(ack),
      .STATE_COMPACT(sc), .SAVED_STATE(ss), .PC_STEP(step), .WIDE_VALID(wv), .DEC_VALID(dv),
      .DEC_CLASS(cls), .DEC_SUBOP(sub), .DEC_RD(drd), .DEC_RS(drs), .DEC_RO(dro), .DEC_IMM(imm),
      .DEC_IMM_SEL(isl), .DEC_SIZE(sz), .DEC_SIGNED(sgn), .DEC_LOAD(ld), .DEC_WRITEBACK(wbk),
      .DEC_REGLIST(rl), .DEC_LR_PC(lrp), .DEC_POP_RETURN(pr), .DEC_BR_TAKEN(tk), .DEC_LINK(lnk),
      .DEC_XCHG(xg), .DEC_XCHG_HIGH(xh));
   initial forever #12.5 clk = ~clk;
   function automatic logic tkx(input logic [3:0] c, input logic [3:0] f);
      logic [13:0] t;
      t = {f[2] | (f[3] ^ f[0]), ~f[2] & ~(f[3] ^ f[0]), f[3] ^ f[0], ~(f[3] ^ f[0]),
           ~f[1] | f[2], f[1] & ~f[2], ~f[0], f[0], ~f[3], f[3], ~f[1], f[1], ~f[2], f[2]};
      return t[c];
   endfunction
   task automatic results;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic dec(input logic [15:0] h, input logic p, input logic [3:0] f);
      @(posedge clk);
      req <= 1'b1;
      hw <= h;
      pc1 <= p;
      nzcv <= f;
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic [4:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 5'h0;
      #1;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = wdo;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         $display("mismatch %0t timeout", $time);
         results();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      `CHK({sc, ss, step}, 5'h04)
      bus(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h1)
      dec(16'h48ff, 1'b0, 4'h0);
      `CHK({dv, wv}, 2'b01)
      pulse(5'h03);
      `CHK({sc, step}, 4'ha)
      foreach (rows[i]) begin
         dec(rows[i][61:46], i[0], 4'h0);
         `CHK({dv, cls}, {1'b1, rows[i][45:41]})
         if (rows[i][45:41] < 5'h05) `CHK(sub, rows[i][40:37])
         if (rows[i][36:5] !== 32'hffffffff) `CHK(imm, rows[i][36:5])
         `CHK({tk, lnk, xg, xh, pr}, rows[i][4:0])
         `CHK({isl, sz, sgn, ld, wbk, lrp}, rows[i][68:62])
         if (rows[i][61:58] == 4'h5) `CHK({drd, drs, dro}, 12'h211)
         if (rows[i][45:41] inside {5'h0e, 5'h0f}) `CHK(rl, rows[i][53:46])
         if (rows[i][45:41] == 5'h14) `CHK(drd, 4'he)
      end
      for (int c = 0; c < 14; c++) begin
         for (int f = 0; f < 16; f++) begin
            dec({4'hd, c[3:0], 8'h02}, f[0], f[3:0]);
            `CHK({dv, cls, sub, imm}, {1'b1, 5'h10, c[3:0], 32'h4})
            `CHK(tk, tkx(c[3:0], f[3:0]))
         end
      end
      // exception and exchange in one cycle: the exception wins
      pulse(5'h13);
      `CHK({sc, ss, step}, 5'h0c)
      pulse({2'b01, ss, 2'b00});
      `CHK({sc, step}, 4'ha)
      bus(1'b1, 8'h00, 32'h0);
      dec(16'h48ff, 1'b1, 4'h0);
      `CHK({dv, wv}, 2'b00)
      bus(1'b0, 8'h0c, 32'h0);
      `CHK(rd, 32'h0)
      bus(1'b0, 8'h04, 32'h0);
      `CHK(rd, 32'h3)
      bus(1'b0, 8'h08, 32'h0);
      `CHK(rd, 32'h3)
      bus(1'b1, 8'h00, 32'h2);
      bus(1'b0, 8'h08, 32'h0);
      `CHK(rd, 32'h0)
      // mid-run reset brings back wide state, enable and idle decode outputs
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      `CHK({sc, ss, step, dv, wv, tk, cls, imm}, {5'h04, 3'h0, 5'h00, 32'h0})
      bus(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h1)
      results();
   end
endmodule
bind cisd_top cisd_top_monitor mon (.*);
`default_nettype wire
